// ==== hdl/ctcf_pkg.sv ====
// Shared constants and types for the touch calibration filter
package ctcf_pkg;
  localparam int NCH = 8;
  localparam int IMPW = 7;
  localparam logic [6:0] IMP_FULL = 7'h7F;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ENV = 8'h04;
  localparam logic [7:0] REG_QUIET = 8'h08;
  localparam logic [7:0] REG_RECAL = 8'h0C;
  localparam logic [7:0] REG_INTEG = 8'h10;
  localparam logic [7:0] REG_SLIM = 8'h14;
  localparam logic [7:0] REG_TOUCH = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1C;
  localparam logic [7:0] BANK_TVR = 8'h20;
  localparam logic [7:0] BANK_CAL = 8'h40;
  localparam logic [7:0] BANK_STR = 8'h60;
  localparam logic [7:0] BANK_SPAN = 8'h20;

  // Field positions
  localparam int CTRL_MODE = 0;
  localparam int CTRL_SCAL = 2;
  localparam int CTRL_SLEEP = 3;
  localparam int CTRL_HIB = 4;
  localparam int CTRL_WAKE = 5;
  localparam int STAT_SLEEPQ = 3;
  localparam int STAT_HIBQ = 4;

  // Reset values
  localparam logic [6:0] ENV_RST = 7'h02;
  localparam logic [15:0] QUIET_RST = 16'h0010;
  localparam logic [15:0] RECAL_RST = 16'h0008;
  localparam logic [7:0] INTEG_RST = 8'h08;
  localparam logic [7:0] SLIM_RST = 8'h04;
  localparam logic [6:0] TVR_RST = 7'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Inactivity time before sleep
  localparam int unsigned SLEEP_IDLE_MS = 100;
  localparam int unsigned CORE_CLK_KHZ = 200000;

  typedef enum logic [1:0] {
    MODE_STRONGEST = 2'h0,
    MODE_ALL = 2'h1,
    MODE_TOP_TWO = 2'h2
  } ctcf_mode_t;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h1,
    PWR_SLEEP = 3'h2,
    PWR_HIBER = 3'h4
  } ctcf_pwr_t;

  typedef struct packed {
    logic valid;
    logic [NCH-1:0][IMPW-1:0] imp;
  } ctcf_meas_t;
endpackage

// ==== hdl/ctcf_top.sv ====
// Touch calibration, integration filter, power states and register slave
`timescale 1ns/1ps
// How it works
// - Each channel keeps touch margin and reference
// - Rise above margin is touch, no recalibration
// - Rise between margins: no touch, reference kept
// - Small rise: no touch, reference follows
// - Fall below reference: reference takes sample
// - Quantities are 127 minus register value
// - Calibrate only after all-quiet period
// - Repeat calibration every recal period
// - Count touches per period as strength
// - Period length and limit are registers
// - Final touch needs strength above limit
// - Strongest, all, or two strongest modes
// - Final touches readable in touch byte
// - Reset pin low holds reset, then active
// - Active goes to sleep after idle time
// - Touch in sleep returns to active
// - Sleep calibration follows control bit
// - Sleep or hibernate order waits for release
module ctcf_top import ctcf_pkg::*; #(
  parameter int unsigned SLEEP_IDLE_CYC = SLEEP_IDLE_MS * CORE_CLK_KHZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic resetPinN,
  input wire ctcf_meas_t meas,
  output logic [NCH-1:0] touchByte,
  output logic [2:0] powerState,
  output logic measEnable,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  if (SLEEP_IDLE_CYC < 1) begin : gBadIdle
    $error("SLEEP_IDLE_CYC must be at least one");
  end

  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctcf_bus_t;

  typedef struct packed {
    logic pinSync1;
    logic pinSync2;
    ctcf_mode_t mode;
    logic sleepCal;
    logic [6:0] envMargin;
    logic [15:0] quietTime;
    logic [15:0] recalPeriod;
    logic [7:0] integLen;
    logic [7:0] strengthLimit;
    logic [NCH-1:0][6:0] tvr;
    logic [NCH-1:0][6:0] cal;
    logic [NCH-1:0][7:0] accum;
    logic [NCH-1:0][7:0] strength;
    logic [NCH-1:0] touchByte;
    logic [7:0] integCnt;
    logic [15:0] quietCnt;
    logic [15:0] recalCnt;
    logic [31:0] idleCnt;
    ctcf_pwr_t pwr;
    logic sleepReq;
    logic hibReq;
    logic wakeReq;
    logic measEn;
    ctcf_bus_t bus;
  } ctcf_state_t;

  ctcf_state_t st_r;
  ctcf_state_t st_nxt;
  logic [NCH-1:0][6:0] impX;
  logic [NCH-1:0] instTouch;
  logic pinOk;
  logic procOn;
  logic sample;
  logic quietOk;
  logic recalDue;
  logic calAllowed;
  logic calNow;
  logic periodEnd;
  logic held;
  logic activity;

  function automatic ctcf_state_t rstState();
    ctcf_state_t s;
    s = '0;
    s.mode = MODE_STRONGEST;
    s.envMargin = ENV_RST;
    s.quietTime = QUIET_RST;
    s.recalPeriod = RECAL_RST;
    s.integLen = INTEG_RST;
    s.strengthLimit = SLIM_RST;
    for (int i = 0; i < NCH; i++) begin
      s.tvr[i] = TVR_RST;
      s.cal[i] = IMP_FULL;
    end
    s.pwr = PWR_ACTIVE;
    s.measEn = 1'b1;
    return s;
  endfunction

  function automatic logic [NCH-1:0] aboveMask(input logic [NCH-1:0][7:0] s,
                                               input logic [7:0] lim);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) begin
      m[i] = s[i] > lim;
    end
    return m;
  endfunction

  // Ties go to the lowest channel so the choice is repeatable
  function automatic logic [3:0] argMax(input logic [NCH-1:0][7:0] s,
                                        input logic [NCH-1:0] m);
    logic [3:0] r;
    logic [7:0] best;
    r = 4'h0;
    best = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (m[i] && (!r[3] || s[i] > best)) begin
        r = {1'b1, 3'(i)};
        best = s[i];
      end
    end
    return r;
  endfunction

  function automatic logic [NCH-1:0] selectTouch(input logic [NCH-1:0][7:0] s,
                                                 input logic [7:0] lim,
                                                 input ctcf_mode_t md);
    logic [NCH-1:0] above;
    logic [NCH-1:0] one;
    logic [NCH-1:0] two;
    logic [3:0] a;
    logic [3:0] b;
    above = aboveMask(s, lim);
    a = argMax(s, above);
    one = a[3] ? (8'h01 << a[2:0]) : 8'h00;
    b = argMax(s, above & ~one);
    two = b[3] ? (8'h01 << b[2:0]) : 8'h00;
    case (md)
      MODE_ALL: selectTouch = above;
      MODE_TOP_TWO: selectTouch = one | two;
      default: selectTouch = one;
    endcase
  endfunction

  function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic bankHit(input logic [7:0] a, input logic [7:0] base);
    return a >= base && a < base + BANK_SPAN;
  endfunction

  // Returns hit flag above the 32-bit read value
  function automatic logic [32:0] regRead(input logic [7:0] a);
    logic [31:0] d;
    logic hit;
    d = 32'h0;
    hit = 1'b1;
    if (a == REG_CTRL) begin
      d[CTRL_MODE +: 2] = st_r.mode;
      d[CTRL_SCAL] = st_r.sleepCal;
      d[CTRL_SLEEP] = st_r.sleepReq;
      d[CTRL_HIB] = st_r.hibReq;
    end else if (a == REG_ENV) begin
      d[6:0] = st_r.envMargin;
    end else if (a == REG_QUIET) begin
      d[15:0] = st_r.quietTime;
    end else if (a == REG_RECAL) begin
      d[15:0] = st_r.recalPeriod;
    end else if (a == REG_INTEG) begin
      d[7:0] = st_r.integLen;
    end else if (a == REG_SLIM) begin
      d[7:0] = st_r.strengthLimit;
    end else if (a == REG_TOUCH) begin
      d[NCH-1:0] = st_r.touchByte;
    end else if (a == REG_STAT) begin
      d[2:0] = st_r.pwr;
      d[STAT_SLEEPQ] = st_r.sleepReq;
      d[STAT_HIBQ] = st_r.hibReq;
    end else if (bankHit(a, BANK_TVR)) begin
      d[6:0] = st_r.tvr[a[4:2]];
    end else if (bankHit(a, BANK_CAL)) begin
      d[6:0] = IMP_FULL - st_r.cal[a[4:2]];
    end else if (bankHit(a, BANK_STR)) begin
      d[7:0] = st_r.strength[a[4:2]];
    end else begin
      hit = 1'b0;
    end
    return {hit, d};
  endfunction

  for (genvar g = 0; g < NCH; g++) begin : gCh
    assign impX[g] = IMP_FULL - meas.imp[g];
    assign instTouch[g] = {1'b0, impX[g]} > ({1'b0, st_r.cal[g]} + {1'b0, st_r.tvr[g]});
  end

  assign pinOk = st_r.pinSync2;
  assign procOn = pinOk && st_r.pwr != PWR_HIBER;
  assign sample = meas.valid && procOn;
  assign quietOk = st_r.quietCnt >= st_r.quietTime;
  assign recalDue = st_r.recalCnt >= st_r.recalPeriod;
  assign calAllowed = st_r.pwr == PWR_ACTIVE || st_r.sleepCal;
  // A touching sample breaks the all-quiet condition for every channel
  assign calNow = sample && !(|instTouch) && quietOk && recalDue && calAllowed;
  assign periodEnd = sample && ({1'b0, st_r.integCnt} + 9'h001 >= {1'b0, st_r.integLen});
  assign held = |st_r.touchByte;
  assign activity = (sample && |instTouch) || held;

  always_comb begin
    logic [NCH-1:0][7:0] acc;
    logic [6:0] rise;
    logic [32:0] rd;
    logic [31:0] wv;
    acc = st_r.accum;
    rise = 7'h00;
    rd = 33'h0;
    wv = 32'h0;
    st_nxt = st_r;
    if (sample) begin
      for (int i = 0; i < NCH; i++) begin
        acc[i] = st_r.accum[i] + {7'h00, instTouch[i]};
        if (calNow && impX[i] > st_r.cal[i]) begin
          rise = impX[i] - st_r.cal[i];
          if (rise <= st_r.tvr[i] && rise <= st_r.envMargin) begin
            st_nxt.cal[i] = st_r.cal[i] + rise;
          end
        end else if (calNow && impX[i] < st_r.cal[i]) begin
          st_nxt.cal[i] = impX[i];
        end
      end
      st_nxt.quietCnt = |instTouch ? 16'h0000 : (quietOk ? st_r.quietCnt : st_r.quietCnt + 16'h0001);
      if (calNow) begin
        st_nxt.recalCnt = 16'h0000;
      end else if (!recalDue) begin
        st_nxt.recalCnt = st_r.recalCnt + 16'h0001;
      end
      if (periodEnd) begin
        st_nxt.strength = acc;
        st_nxt.touchByte = selectTouch(acc, st_r.strengthLimit, st_r.mode);
        st_nxt.accum = '0;
        st_nxt.integCnt = 8'h00;
      end else begin
        st_nxt.accum = acc;
        st_nxt.integCnt = st_r.integCnt + 8'h01;
      end
    end
    case (st_r.pwr)
      PWR_ACTIVE: begin
        st_nxt.wakeReq = 1'b0;
        if (st_r.hibReq && !held) begin
          st_nxt.pwr = PWR_HIBER;
          st_nxt.hibReq = 1'b0;
          st_nxt.sleepReq = 1'b0;
          st_nxt.idleCnt = 32'h0;
        end else if (st_r.sleepReq && !held) begin
          st_nxt.pwr = PWR_SLEEP;
          st_nxt.sleepReq = 1'b0;
          st_nxt.idleCnt = 32'h0;
        end else if (activity) begin
          st_nxt.idleCnt = 32'h0;
        end else if (st_r.idleCnt >= SLEEP_IDLE_CYC - 1) begin
          st_nxt.pwr = PWR_SLEEP;
          st_nxt.idleCnt = 32'h0;
        end else begin
          st_nxt.idleCnt = st_r.idleCnt + 32'h1;
        end
      end
      PWR_SLEEP: begin
        st_nxt.sleepReq = 1'b0;
        st_nxt.wakeReq = 1'b0;
        if (sample && |instTouch) begin
          st_nxt.pwr = PWR_ACTIVE;
        end else if (st_r.hibReq && !held) begin
          st_nxt.pwr = PWR_HIBER;
          st_nxt.hibReq = 1'b0;
        end
      end
      PWR_HIBER: begin
        st_nxt.sleepReq = 1'b0;
        st_nxt.hibReq = 1'b0;
        st_nxt.wakeReq = 1'b0;
        if (st_r.wakeReq) begin
          st_nxt.pwr = PWR_ACTIVE;
        end
      end
      default: begin
        st_nxt.pwr = PWR_ACTIVE;
      end
    endcase
    st_nxt.measEn = st_nxt.pwr != PWR_HIBER;
    // Pin reset spares the synchroniser and the bus so it cannot lock up
    if (!pinOk) begin
      st_nxt = rstState();
    end
    st_nxt.pinSync1 = resetPinN;
    st_nxt.pinSync2 = st_r.pinSync1;
    st_nxt.bus = st_r.bus;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.bus.awHave = 1'b1;
      st_nxt.bus.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.bus.wHave = 1'b1;
      st_nxt.bus.wData = s_axi_wdata;
      st_nxt.bus.wStrb = s_axi_wstrb;
    end
    if (st_r.bus.awHave && st_r.bus.wHave) begin
      rd = regRead(st_r.bus.awAddr);
      wv = strbMerge(rd[31:0], st_r.bus.wData, st_r.bus.wStrb);
      if (pinOk) begin
        // Command bits come after the state machine, so a set beats a clear
        if (st_r.bus.awAddr == REG_CTRL) begin
          st_nxt.mode = ctcf_mode_t'(wv[CTRL_MODE +: 2]);
          st_nxt.sleepCal = wv[CTRL_SCAL];
          st_nxt.sleepReq = st_nxt.sleepReq | wv[CTRL_SLEEP];
          st_nxt.hibReq = st_nxt.hibReq | wv[CTRL_HIB];
          st_nxt.wakeReq = st_nxt.wakeReq | wv[CTRL_WAKE];
        end else if (st_r.bus.awAddr == REG_ENV) begin
          st_nxt.envMargin = wv[6:0];
        end else if (st_r.bus.awAddr == REG_QUIET) begin
          st_nxt.quietTime = wv[15:0];
        end else if (st_r.bus.awAddr == REG_RECAL) begin
          st_nxt.recalPeriod = wv[15:0];
        end else if (st_r.bus.awAddr == REG_INTEG) begin
          st_nxt.integLen = wv[7:0];
        end else if (st_r.bus.awAddr == REG_SLIM) begin
          st_nxt.strengthLimit = wv[7:0];
        end else if (bankHit(st_r.bus.awAddr, BANK_TVR)) begin
          st_nxt.tvr[st_r.bus.awAddr[4:2]] = wv[6:0];
        end
      end
      st_nxt.bus.awHave = 1'b0;
      st_nxt.bus.wHave = 1'b0;
      st_nxt.bus.bvalid = 1'b1;
      st_nxt.bus.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.bus.bvalid && s_axi_bready) begin
      st_nxt.bus.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd = regRead(s_axi_araddr);
      st_nxt.bus.rvalid = 1'b1;
      st_nxt.bus.rdata = rd[31:0];
      st_nxt.bus.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.bus.rvalid && s_axi_rready) begin
      st_nxt.bus.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= rstState();
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = !st_r.bus.awHave && !st_r.bus.bvalid;
  assign s_axi_wready = !st_r.bus.wHave && !st_r.bus.bvalid;
  assign s_axi_bvalid = st_r.bus.bvalid;
  assign s_axi_bresp = st_r.bus.bresp;
  assign s_axi_arready = !st_r.bus.rvalid;
  assign s_axi_rvalid = st_r.bus.rvalid;
  assign s_axi_rdata = st_r.bus.rdata;
  assign s_axi_rresp = st_r.bus.rresp;
  assign touchByte = st_r.touchByte;
  assign powerState = st_r.pwr;
  assign measEnable = st_r.measEn;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence sCh0Sample;
    sample && calNow && pinOk;
  endsequence

  sequence sHeldActive;
    st_r.pwr == PWR_ACTIVE && held && pinOk;
  endsequence

  touch_nocal_a: assert property (
    sample && instTouch[0] |=> !pinOk || st_r.cal[0] == $past(st_r.cal[0]))
    else $error("reference moved on a touch");
  env_hold_a: assert property (
    sCh0Sample ##0 (impX[0] > st_r.cal[0]) ##0 !instTouch[0]
    ##0 (impX[0] - st_r.cal[0] > st_r.envMargin) |=> st_r.cal[0] == $past(st_r.cal[0]))
    else $error("reference moved above environmental margin");
  env_track_a: assert property (
    sCh0Sample ##0 (impX[0] > st_r.cal[0]) ##0 !instTouch[0]
    ##0 (impX[0] - st_r.cal[0] <= st_r.envMargin) |=> st_r.cal[0] == $past(impX[0]))
    else $error("reference did not follow small rise");
  fall_recal_a: assert property (
    sCh0Sample ##0 (impX[0] < st_r.cal[0]) |=> st_r.cal[0] == $past(impX[0]))
    else $error("reference did not take lower sample");
  quiet_gate_a: assert property (
    pinOk && st_r.cal != $past(st_r.cal) && $past(pinOk) |-> $past(quietOk) && $past(recalDue))
    else $error("calibration without quiet time");
  limit_all_a: assert property (
    periodEnd && st_r.mode == MODE_ALL && pinOk
    |=> !pinOk || st_r.touchByte == aboveMask(st_r.strength, $past(st_r.strengthLimit)))
    else $error("all-mode byte does not match strengths");
  mode_count_a: assert property (
    periodEnd && st_r.mode != MODE_ALL && pinOk
    |=> $countones(st_r.touchByte) <= (($past(st_r.mode) == MODE_TOP_TWO) ? 2 : 1))
    else $error("too many channels in selective mode");
  pin_reset_a: assert property (
    !pinOk |=> st_r.pwr == PWR_ACTIVE && st_r.touchByte == 8'h00 && st_r.measEn)
    else $error("pin reset did not restore active state");
  idle_sleep_a: assert property (
    st_r.pwr == PWR_ACTIVE && pinOk && !activity && !st_r.hibReq
    && st_r.idleCnt >= SLEEP_IDLE_CYC - 1 |=> st_r.pwr == PWR_SLEEP)
    else $error("idle time did not lead to sleep");
  sleep_wake_a: assert property (
    st_r.pwr == PWR_SLEEP && sample && |instTouch |=> st_r.pwr == PWR_ACTIVE)
    else $error("touch in sleep did not wake");
  sleep_nocal_a: assert property (
    st_r.pwr == PWR_SLEEP && !st_r.sleepCal && pinOk |=> st_r.cal == $past(st_r.cal))
    else $error("calibration ran in sleep while disabled");
  defer_cmd_a: assert property (
    sHeldActive |=> st_r.pwr == PWR_ACTIVE)
    else $error("left active while a key was held");
  period_clear_a: assert property (
    periodEnd && pinOk |=> st_r.accum == '0 && st_r.integCnt == 8'h00)
    else $error("count not cleared at period end");
endmodule

// ==== tb/ctcf_pad_model.sv ====
// Sensing pad model: periodic impedance samples for all channels
`timescale 1ns/1ps
module ctcf_pad_model import ctcf_pkg::*; #(
  parameter int GAP = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [NCH-1:0][IMPW-1:0] level,
  output ctcf_meas_t meas
);
  logic [7:0] gapCnt_r;
  logic fire;
  assign fire = enable && (gapCnt_r == 8'(GAP - 1));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gapCnt_r <= 8'h00;
      meas <= '0;
    end else begin
      gapCnt_r <= (gapCnt_r == 8'(GAP - 1)) ? 8'h00 : gapCnt_r + 8'h01;
      meas.valid <= fire;
      // Readout means nothing between samples, so it keeps changing
      meas.imp <= fire ? level : ~meas.imp;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the touch calibration filter
`timescale 1ns/1ps
module testbench import ctcf_pkg::*;;
  logic core_clk, rst, resetPinN, measEnable;
  ctcf_meas_t meas;
  logic [NCH-1:0] touchByte;
  logic [2:0] powerState;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NCH-1:0][IMPW-1:0] level;
  int errors, check_count;

  // Short idle time so the sleep entry fits the run
  ctcf_top #(.SLEEP_IDLE_CYC(1000)) u_ctcf_top (
    .core_clk, .rst, .resetPinN, .meas, .touchByte, .powerState, .measEnable,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp
  );
  ctcf_pad_model u_ctcf_pad_model (
    .core_clk, .rst, .enable(measEnable), .level, .meas
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Ready is sampled mid-cycle; the item moves at the following edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = s_axi_awready && !da;
      tw = s_axi_wready && !dw;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    do begin
      @(negedge core_clk);
      ta = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
    end while (!ta);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      t = s_axi_arready;
      @(posedge core_clk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge core_clk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(d, exp, "read data");
    chk({30'h0, r}, {30'h0, er}, "read resp");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write resp");
  endtask

  task automatic samples(input int n);
    repeat (n) begin
      @(negedge core_clk);
      while (meas.valid !== 1'b1) @(negedge core_clk);
    end
  endtask

  task automatic set_level(input int ch, input logic [6:0] v);
    @(posedge core_clk);
    level[ch] <= v;
  endtask

  task automatic wait_pwr(input logic [2:0] exp, input int lim);
    int n;
    n = 0;
    while (powerState !== exp && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk({29'h0, powerState}, {29'h0, exp}, "power state");
  endtask

  // Period-4 pattern: any four samples give ch0 4, ch1 3, ch2 2 touches
  task automatic pattern(input int n);
    samples(1);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      level[0] <= 7'h50;
      level[1] <= (k % 4 == 0) ? 7'h64 : 7'h50;
      level[2] <= (k % 4 < 2) ? 7'h50 : 7'h64;
      samples(1);
    end
  endtask

  task automatic test_reset();
    logic [1:0] r;
    chk_reg(BANK_CAL, 32'h0);
    chk_reg(REG_ENV, {25'h0, ENV_RST});
    chk_reg(REG_QUIET, {16'h0, QUIET_RST});
    chk_reg(REG_RECAL, {16'h0, RECAL_RST});
    chk_reg(REG_INTEG, {24'h0, INTEG_RST});
    chk_reg(REG_SLIM, {24'h0, SLIM_RST});
    chk_reg(BANK_TVR + 8'h1C, {25'h0, TVR_RST});
    wr(BANK_TVR + 8'h1C, 32'hA);
    chk_reg(BANK_TVR + 8'h1C, 32'hA);
    chk_reg(REG_STAT, 32'h1);
    wr(REG_TOUCH, 32'hFF);
    chk_reg(REG_TOUCH, 32'h0);
    axi_write(8'h80, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    chk_reg(8'h80, 32'h0, RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic test_calib();
    samples(30);
    chk_reg(BANK_CAL, 32'h64);
    chk_reg(BANK_CAL + 8'h14, 32'h64);
    wr(REG_RECAL, 32'h28);
    wr(REG_QUIET, 32'h1);
    set_level(0, 7'h63);
    samples(20);
    chk_reg(BANK_CAL, 32'h64);
    samples(25);
    chk_reg(BANK_CAL, 32'h63);
    wr(REG_RECAL, 32'h1);
    set_level(0, 7'h60);
    samples(6);
    chk_reg(BANK_CAL, 32'h63);
    set_level(0, 7'h5B);
    samples(20);
    chk_reg(BANK_STR, 32'h0);
    set_level(0, 7'h5A);
    samples(20);
    chk_reg(BANK_STR, 32'h8);
    chk({24'h0, touchByte}, 32'h1, "touch byte");
    chk_reg(BANK_CAL, 32'h63);
    set_level(0, 7'h69);
    samples(20);
    chk_reg(BANK_CAL, 32'h69);
    chk({24'h0, touchByte}, 32'h0, "touch byte");
    $display("test calib done");
  endtask

  task automatic test_filter();
    wr(REG_INTEG, 32'h4);
    wr(REG_SLIM, 32'h3);
    wr(REG_CTRL, {30'h0, MODE_ALL});
    fork
      pattern(80);
      begin
        samples(10);
        chk({24'h0, touchByte}, 32'h1, "limit");
        chk_reg(BANK_STR, 32'h4);
        chk_reg(BANK_STR + 8'h04, 32'h3);
        chk_reg(BANK_STR + 8'h08, 32'h2);
        wr(REG_SLIM, 32'h1);
        wr(REG_CTRL, {30'h0, MODE_STRONGEST});
        samples(10);
        chk({24'h0, touchByte}, 32'h1, "strongest");
        // Unused mode code falls back to strongest
        wr(REG_CTRL, 32'h3);
        samples(10);
        chk({24'h0, touchByte}, 32'h1, "mode three");
        wr(REG_CTRL, {30'h0, MODE_ALL});
        samples(10);
        chk({24'h0, touchByte}, 32'h7, "all");
        wr(REG_CTRL, {30'h0, MODE_TOP_TWO});
        samples(10);
        chk({24'h0, touchByte}, 32'h3, "two");
        chk_reg(REG_TOUCH, 32'h3);
      end
    join
    @(posedge core_clk);
    level <= {NCH{7'h64}};
    $display("test filter done");
  endtask

  task automatic test_power();
    wait_pwr(PWR_SLEEP, 1500);
    set_level(3, 7'h6E);
    samples(6);
    chk_reg(BANK_CAL + 8'h0C, 32'h64);
    wr(REG_CTRL, 32'h4);
    samples(6);
    chk_reg(BANK_CAL + 8'h0C, 32'h6E);
    set_level(3, 7'h64);
    wait_pwr(PWR_ACTIVE, 40);
    samples(10);
    chk({24'h0, touchByte}, 32'h8, "held key");
    wr(REG_CTRL, 32'hC);
    samples(4);
    chk({29'h0, powerState}, {29'h0, PWR_ACTIVE}, "deferred");
    chk_reg(REG_STAT, 32'h9);
    set_level(3, 7'h6E);
    wait_pwr(PWR_SLEEP, 100);
    set_level(3, 7'h64);
    wait_pwr(PWR_ACTIVE, 40);
    samples(10);
    wr(REG_CTRL, 32'h14);
    set_level(3, 7'h6E);
    wait_pwr(PWR_HIBER, 100);
    chk({31'h0, measEnable}, 32'h0, "front end off");
    wr(REG_CTRL, 32'h24);
    wait_pwr(PWR_ACTIVE, 20);
    chk({31'h0, measEnable}, 32'h1, "front end on");
    @(posedge core_clk);
    resetPinN <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk({29'h0, powerState}, {29'h0, PWR_ACTIVE}, "pin reset");
    chk({24'h0, touchByte}, 32'h0, "pin reset");
    resetPinN <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk_reg(REG_QUIET, {16'h0, QUIET_RST});
    $display("test power done");
  endtask

  initial begin
    #100000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    errors = 0;
    check_count = 0;
    rst = 1'b1;
    resetPinN = 1'b1;
    level = {NCH{7'h64}};
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    test_reset();
    test_calib();
    test_filter();
    test_power();
    summarize();
  end
endmodule
